// File: clkg_pkg.sv
// clkg_pkg: offsets, field positions, reset values and counts of the
// clock generator control block; shared by the design and its bench.
package clkg_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFF_FREQ_MEAS = 8'h04;
    localparam logic [7:0] OFF_SYNTH_CFG = 8'h08;
    localparam logic [7:0] OFF_PWR_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    // osc_control_reg fields
    localparam int OSC_EN_POS = 0;
    localparam int OSC_BYP_POS = 1;
    localparam int OSC_CNT_LSB = 8;
    localparam int OSC_CNT_W = 8;
    // freq_measure_reg fields
    localparam int TALLY_W = 16;
    localparam int MEAS_DONE_POS = 16;
    // synth_config_reg fields
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 8;
    localparam int SETTLE_LSB = 8;
    localparam int SETTLE_W = 6;
    localparam int MUL_LSB = 16;
    localparam int MUL_W = 11;
    // power_status_reg and power_irq_mask_reg fields
    localparam int ST_OSC_POS = 0;
    localparam int ST_PLL_POS = 2;
    // timing counts
    localparam logic [2:0] OSC_PRESCALE_LAST = 3'h7;
    localparam logic [4:0] MEAS_SLOW_PERIODS = 5'h10;
    // reset values
    localparam logic [31:0] OSC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SYNTH_CFG_RST = 32'h0000_0000;
    // frequency measurement states
    typedef enum logic [1:0] {
        MEAS_IDLE = 2'b00,
        MEAS_ARM = 2'b01,
        MEAS_RUN = 2'b10,
        MEAS_DONE = 2'b11
    } clkg_meas_e;
endpackage

// File: clkg_top.sv
// clkg_top: clock generator control, main oscillator and pll sequencing
// assumes slow and main clock levels arrive synchronous to MCLK_I and
// run well below half its rate; classic wishbone slave, 32-bit data
`timescale 1ns/1ns
module clkg_top
    import clkg_pkg::*;
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic SRST_I,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // clock levels sampled from the analog side
    input wire logic SLOW_CLOCK_I,
    input wire logic MAIN_OSC_CLOCK_I,
    // analog oscillator and pll controls
    output logic OSC_ENABLE_O,
    output logic OSC_BYPASS_O,
    output logic SLOW_SELECT_O,
    output logic [DIV_W-1:0] PLL_DIV_O,
    output logic [MUL_W-1:0] PLL_MUL_O,
    output logic PLL_POWER_DOWN_O,
    output logic PLL_OUT_LOW_O,
    // interrupt
    output logic IRQ_O
);
    logic [31:0] osc_ctrl_reg;
    logic [31:0] synth_cfg_reg;
    logic [2:0] irq_mask_reg;
    logic osc_stable_reg;
    logic pll_settled_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic slow_d_reg;
    logic main_d_reg;
    logic slow_rise;
    logic slow_fall;
    logic main_rise;
    logic wr_osc;
    logic wr_synth;
    logic wr_mask;
    logic [31:0] osc_next;
    logic [31:0] synth_next;
    logic [OSC_CNT_W-1:0] osc_cnt_reg;
    logic [2:0] osc_pre_reg;
    logic osc_run_reg;
    logic osc_zero_reg;
    logic [SETTLE_W-1:0] pll_cnt_reg;
    logic pll_run_reg;
    logic pll_zero_reg;
    clkg_meas_e meas_state_reg;
    logic [TALLY_W-1:0] tally_reg;
    logic [4:0] fall_cnt_reg;
    logic [31:0] rd_mux;

    // byte-lane merge of write data into a register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // write strobes fire on the edge where ack is seen by the master
    always_comb begin
        wr_osc = 1'b0;
        wr_synth = 1'b0;
        wr_mask = 1'b0;
        if (WB_CYC_I && WB_STB_I && WB_WE_I && ack_reg) begin
            wr_osc = (WB_ADR_I == OFF_OSC_CTRL);
            wr_synth = (WB_ADR_I == OFF_SYNTH_CFG);
            wr_mask = (WB_ADR_I == OFF_IRQ_MASK);
        end
        osc_next = merge(osc_ctrl_reg, WB_DAT_I, WB_SEL_I);
        synth_next = merge(synth_cfg_reg, WB_DAT_I, WB_SEL_I);
    end

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= WB_CYC_I && WB_STB_I && !ack_reg;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (WB_ADR_I)
            OFF_OSC_CTRL: rd_mux = osc_ctrl_reg;
            OFF_FREQ_MEAS: begin
                rd_mux[TALLY_W-1:0] = tally_reg;
                rd_mux[MEAS_DONE_POS] = (meas_state_reg == MEAS_DONE);
            end
            OFF_SYNTH_CFG: rd_mux = synth_cfg_reg;
            OFF_PWR_STATUS: begin
                rd_mux[ST_OSC_POS] = osc_stable_reg;
                rd_mux[ST_PLL_POS] = pll_settled_reg;
            end
            OFF_IRQ_MASK: rd_mux[2:0] = irq_mask_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data registered with the ack
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            rdat_reg <= 32'h0000_0000;
        end else if (WB_CYC_I && WB_STB_I && !ack_reg) begin
            rdat_reg <= rd_mux;
        end
    end

    // configuration registers; divider and oscillator start cleared
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            osc_ctrl_reg <= OSC_CTRL_RST;
            synth_cfg_reg <= SYNTH_CFG_RST;
            irq_mask_reg <= 3'h0;
        end else begin
            if (wr_osc) begin
                osc_ctrl_reg <= {16'h0000, osc_next[15:8], 6'h00,
                                 osc_next[1:0]};
            end
            if (wr_synth) begin
                synth_cfg_reg <= {5'h00, osc_zero(synth_next)};
            end
            if (wr_mask) begin
                irq_mask_reg <= {WB_DAT_I[ST_PLL_POS], 1'b0,
                                 WB_DAT_I[ST_OSC_POS]};
            end
        end
    end

    // keep only the defined synth fields
    function automatic logic [26:0] osc_zero(input logic [31:0] v);
        logic [26:0] r;
        r = 27'h0;
        r[MUL_LSB +: MUL_W] = v[MUL_LSB +: MUL_W];
        r[SETTLE_LSB +: SETTLE_W] = v[SETTLE_LSB +: SETTLE_W];
        r[DIV_LSB +: DIV_W] = v[DIV_LSB +: DIV_W];
        return r;
    endfunction

    // edge detection of the sampled clock levels
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            slow_d_reg <= 1'b0;
            main_d_reg <= 1'b0;
        end else begin
            slow_d_reg <= SLOW_CLOCK_I;
            main_d_reg <= MAIN_OSC_CLOCK_I;
        end
    end
    assign slow_rise = SLOW_CLOCK_I && !slow_d_reg;
    assign slow_fall = !SLOW_CLOCK_I && slow_d_reg;
    assign main_rise = MAIN_OSC_CLOCK_I && !main_d_reg;

    // startup down-counter, one step per eight slow periods
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            osc_cnt_reg <= '0;
            osc_pre_reg <= 3'h0;
            osc_run_reg <= 1'b0;
            osc_zero_reg <= 1'b0;
        end else begin
            osc_zero_reg <= 1'b0;
            if (wr_osc) begin
                osc_cnt_reg <= osc_next[OSC_CNT_LSB +: OSC_CNT_W];
                osc_pre_reg <= 3'h0;
                osc_run_reg <= osc_next[OSC_EN_POS];
            end else if (osc_run_reg && osc_cnt_reg == '0) begin
                osc_run_reg <= 1'b0;
                osc_zero_reg <= 1'b1;
            end else if (osc_run_reg && slow_rise) begin
                osc_pre_reg <= osc_pre_reg + 3'h1;
                if (osc_pre_reg == OSC_PRESCALE_LAST) begin
                    osc_cnt_reg <= osc_cnt_reg - OSC_CNT_W'(1);
                end
            end
        end
    end

    // oscillator stable flag; any write to the oscillator control register clears it
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            osc_stable_reg <= 1'b0;
        end else if (wr_osc) begin
            osc_stable_reg <= 1'b0;
        end else if (osc_zero_reg && osc_ctrl_reg[OSC_EN_POS]) begin
            osc_stable_reg <= 1'b1;
        end
    end

    // pll settle counter, one step per slow period
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            pll_cnt_reg <= '0;
            pll_run_reg <= 1'b0;
            pll_zero_reg <= 1'b0;
        end else begin
            pll_zero_reg <= 1'b0;
            if (wr_synth) begin
                pll_cnt_reg <= synth_next[SETTLE_LSB +: SETTLE_W];
                pll_run_reg <= (synth_next[MUL_LSB +: MUL_W] != '0);
            end else if (pll_run_reg && pll_cnt_reg == '0) begin
                pll_run_reg <= 1'b0;
                pll_zero_reg <= 1'b1;
            end else if (pll_run_reg && slow_rise) begin
                pll_cnt_reg <= pll_cnt_reg - SETTLE_W'(1);
            end
        end
    end

    // pll settled flag
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            pll_settled_reg <= 1'b0;
        end else if (wr_synth) begin
            pll_settled_reg <= 1'b0;
        end else if (pll_zero_reg && PLL_MUL_O != '0) begin
            pll_settled_reg <= 1'b1;
        end
    end

    // main clock frequency measurement over sixteen slow periods
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            meas_state_reg <= MEAS_IDLE;
            tally_reg <= '0;
            fall_cnt_reg <= 5'h00;
        end else if (!osc_stable_reg) begin
            meas_state_reg <= MEAS_IDLE;
        end else begin
            case (meas_state_reg)
                MEAS_IDLE: begin
                    tally_reg <= '0;
                    fall_cnt_reg <= 5'h00;
                    meas_state_reg <= MEAS_ARM;
                end
                MEAS_ARM: begin
                    if (slow_rise) begin
                        meas_state_reg <= MEAS_RUN;
                    end
                end
                MEAS_RUN: begin
                    if (main_rise) begin
                        tally_reg <= tally_reg + TALLY_W'(1);
                    end
                    if (slow_fall) begin
                        fall_cnt_reg <= fall_cnt_reg + 5'h01;
                        if (fall_cnt_reg + 5'h01 == MEAS_SLOW_PERIODS) begin
                            meas_state_reg <= MEAS_DONE;
                        end
                    end
                end
                MEAS_DONE: meas_state_reg <= MEAS_DONE;
                default: meas_state_reg <= MEAS_IDLE;
            endcase
        end
    end

    // outputs to the analog side and the processor
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdat_reg;
    assign OSC_ENABLE_O = osc_ctrl_reg[OSC_EN_POS];
    assign OSC_BYPASS_O = osc_ctrl_reg[OSC_BYP_POS];
    assign SLOW_SELECT_O = 1'b1;
    assign PLL_DIV_O = synth_cfg_reg[DIV_LSB +: DIV_W];
    assign PLL_MUL_O = synth_cfg_reg[MUL_LSB +: MUL_W];
    assign PLL_POWER_DOWN_O = (PLL_MUL_O == '0);
    assign PLL_OUT_LOW_O = (PLL_DIV_O == '0);
    assign IRQ_O = (osc_stable_reg && irq_mask_reg[ST_OSC_POS])
        || (pll_settled_reg && irq_mask_reg[ST_PLL_POS]);
endmodule

// File: clkg_osc_model.sv
// clkg_osc_model: stand-in for the analog oscillator and pll macro
// assumes levels launched on MCLK_I rising edges, below half its rate
`timescale 1ns/1ns
module clkg_osc_model #(
    parameter int SLOW_HALF = 8,
    parameter int MAIN_HALF = 2
) (
    // system clock
    input wire logic mclk_i,
    // oscillator controls
    input wire logic osc_en_i,
    input wire logic osc_byp_i,
    // clock levels
    output logic slow_o,
    output logic main_o
);
    int slow_cnt = 0;
    int main_cnt = 0;
    logic slow_lvl = 1'b0;
    logic main_lvl = 1'b0;
    // levels start low, one driver each
    assign slow_o = slow_lvl;
    assign main_o = main_lvl;
    // slow clock runs from time zero and never stops
    always @(posedge mclk_i) begin
        slow_cnt <= (slow_cnt + 1) % SLOW_HALF;
        if (slow_cnt == SLOW_HALF - 1) begin
            slow_lvl <= ~slow_lvl;
        end
    end
    // main clock from crystal or bypass input, else stands low
    always @(posedge mclk_i) begin
        main_cnt <= (main_cnt + 1) % MAIN_HALF;
        if (!(osc_en_i || osc_byp_i)) begin
            main_lvl <= 1'b0;
        end else if (main_cnt == MAIN_HALF - 1) begin
            main_lvl <= ~main_lvl;
        end
    end
endmodule

// File: clkg_asserts.sv
// clkg_asserts: port-level checks of the clock generator control block
// assumes a classic wishbone master on the register port
`timescale 1ns/1ns
module clkg_asserts
    import clkg_pkg::*;
(
    // clock, reset and bus
    input wire logic MCLK_I,
    input wire logic SRST_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    // controls and interrupt
    input wire logic OSC_ENABLE_O,
    input wire logic SLOW_SELECT_O,
    input wire logic [DIV_W-1:0] PLL_DIV_O,
    input wire logic [MUL_W-1:0] PLL_MUL_O,
    input wire logic PLL_POWER_DOWN_O,
    input wire logic PLL_OUT_LOW_O,
    input wire logic IRQ_O
);
    logic take;
    logic wr;
    // request taken, and a write on the low lane
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr = take && WB_WE_I && WB_SEL_I[0];
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (SRST_I);
    property p_ack_lat; take |=> WB_ACK_O; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_slow_sel; SLOW_SELECT_O; endproperty
    a_slow_sel: assert property (p_slow_sel) else $error("slow off");
    property p_div_low; PLL_OUT_LOW_O == (PLL_DIV_O == '0); endproperty
    a_div_low: assert property (p_div_low) else $error("div low");
    property p_mul_off; PLL_POWER_DOWN_O == (PLL_MUL_O == '0); endproperty
    a_mul_off: assert property (p_mul_off) else $error("pll pd");
    property p_osc_wr; wr && WB_ADR_I == OFF_OSC_CTRL |=> ##1
        OSC_ENABLE_O == $past(WB_DAT_I[OSC_EN_POS]); endproperty
    a_osc_wr: assert property (p_osc_wr) else $error("osc en");
    property p_div_wr; wr && WB_ADR_I == OFF_SYNTH_CFG |=> ##1
        PLL_DIV_O == $past(WB_DAT_I[DIV_W-1:0]); endproperty
    a_div_wr: assert property (p_div_wr) else $error("div wr");
    property p_mask_off; take && WB_WE_I && WB_ADR_I == OFF_IRQ_MASK
        && WB_DAT_I == '0 |=> ##1 !IRQ_O; endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq");
    property p_rst_val; disable iff (1'b0) $fell(SRST_I) |-> PLL_DIV_O ==
        '0 && PLL_POWER_DOWN_O && !OSC_ENABLE_O && !IRQ_O; endproperty
    a_rst_val: assert property (p_rst_val) else $error("rst val");
    // main scenarios reached
    c_osc: cover property (OSC_ENABLE_O ##1 IRQ_O);
    c_pll: cover property (!PLL_POWER_DOWN_O && !PLL_OUT_LOW_O);
    c_irq: cover property ($fell(IRQ_O));
endmodule
bind clkg_top clkg_asserts i_clkg_asserts (.MCLK_I, .SRST_I, .WB_CYC_I,
    .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_ACK_O,
    .OSC_ENABLE_O, .SLOW_SELECT_O, .PLL_DIV_O, .PLL_MUL_O,
    .PLL_POWER_DOWN_O, .PLL_OUT_LOW_O, .IRQ_O);

// File: tb_top.sv
// tb_top: self-checking bench of the clock generator control block
// assumes clkg_osc_model in place of the analog oscillator and pll
`timescale 1ns/1ns
module tb_top;
    import clkg_pkg::*;
    logic MCLK_I = 1'b0;
    logic SRST_I = 1'b1;
    logic WB_REQ = 1'b0;
    logic WB_WE_I = 1'b0;
    logic [7:0] WB_ADR_I = 8'h00;
    logic [31:0] WB_DAT_I = 32'h0;
    logic [31:0] WB_DAT_O, rd;
    logic WB_ACK_O, SLOW_CLOCK_I, MAIN_OSC_CLOCK_I, OSC_ENABLE_O;
    logic OSC_BYPASS_O, SLOW_SELECT_O, PLL_POWER_DOWN_O, PLL_OUT_LOW_O;
    logic IRQ_O;
    logic [DIV_W-1:0] PLL_DIV_O;
    logic [MUL_W-1:0] PLL_MUL_O;
    int miscompares = 0;
    int checks_done = 0;
    int now = 0;
    // clock and cycle count
    always #2 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) now <= now + 1;
    clkg_top i_clkg_top (.MCLK_I, .SRST_I, .WB_CYC_I(WB_REQ),
        .WB_STB_I(WB_REQ), .WB_WE_I, .WB_ADR_I, .WB_SEL_I(4'hF), .WB_DAT_I,
        .WB_DAT_O, .WB_ACK_O, .SLOW_CLOCK_I, .MAIN_OSC_CLOCK_I,
        .OSC_ENABLE_O, .OSC_BYPASS_O, .SLOW_SELECT_O, .PLL_DIV_O,
        .PLL_MUL_O, .PLL_POWER_DOWN_O, .PLL_OUT_LOW_O, .IRQ_O);
    clkg_osc_model i_clkg_osc_model (.mclk_i(MCLK_I),
        .osc_en_i(OSC_ENABLE_O), .osc_byp_i(OSC_BYPASS_O),
        .slow_o(SLOW_CLOCK_I), .main_o(MAIN_OSC_CLOCK_I));
    // compare and count
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s: %h not %h", $time, m, got, exp);
        end
    endtask
    // one classic wishbone cycle, read data left in rd; waits for ack,
    // which must come one cycle after the taking edge
    task automatic wb(input logic we, input logic [7:0] a, input int d);
        int n;
        n = 0;
        @(posedge MCLK_I);
        WB_REQ <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        do begin
            @(posedge MCLK_I);
            n++;
        end while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O;
        WB_REQ <= 1'b0;
        chk(n, 2, "ack latency");
    endtask
    // read until a bit is set or 900 cycles pass, t gives the cycles spent
    task automatic poll(input logic [7:0] a, input int b, output int t);
        int t0;
        t0 = now;
        do wb(1'b0, a, 0); while (rd[b] !== 1'b1 && now - t0 < 900);
        t = now - t0;
        chk(rd[b], 1'b1, "poll");
    endtask
    task automatic t_reset;
        wb(1'b0, OFF_OSC_CTRL, 0);
        chk(rd, OSC_CTRL_RST, "osc rst");
        wb(1'b0, OFF_SYNTH_CFG, 0);
        chk(rd, SYNTH_CFG_RST, "div rst");
        chk(PLL_OUT_LOW_O, 1'b1, "pll low");
        wb(1'b1, OFF_PWR_STATUS, -1);
        wb(1'b0, OFF_PWR_STATUS, 0);
        chk(rd, 32'h0, "status ro");
        wb(1'b1, 8'h20, -1);
        wb(1'b0, 8'h20, 0);
        chk(rd, 32'h0, "unmapped");
        $display("reset test done");
    endtask
    task automatic t_osc;
        int t;
        wb(1'b1, OFF_IRQ_MASK, 1);
        wb(1'b1, OFF_OSC_CTRL, 32'h0301);
        poll(OFF_PWR_STATUS, ST_OSC_POS, t);
        chk(32'(t >= 272 && t <= 440), 32'h1, "startup");
        chk(IRQ_O, 1'b1, "osc irq");
        poll(OFF_FREQ_MEAS, MEAS_DONE_POS, t);
        chk(32'(rd[15:0] >= 60 && rd[15:0] <= 65), 32'h1, "tally");
        wb(1'b1, OFF_OSC_CTRL, 32'h0302);
        wb(1'b0, OFF_PWR_STATUS, 0);
        chk(rd[ST_OSC_POS], 1'b0, "stable off");
        chk(IRQ_O, 1'b0, "irq off");
        chk({OSC_BYPASS_O, OSC_ENABLE_O}, 2'h2, "bypass");
        $display("osc test done");
    endtask
    task automatic t_pll;
        int t;
        wb(1'b1, OFF_IRQ_MASK, 4);
        wb(1'b1, OFF_SYNTH_CFG, 32'h0005_0400);
        poll(OFF_PWR_STATUS, ST_PLL_POS, t);
        chk(32'(t >= 48 && t <= 110), 32'h1, "settle");
        chk(PLL_OUT_LOW_O, 1'b1, "div zero");
        chk(IRQ_O, 1'b1, "pll irq");
        wb(1'b1, OFF_IRQ_MASK, 0);
        @(posedge MCLK_I);
        chk(IRQ_O, 1'b0, "masked");
        wb(1'b1, OFF_SYNTH_CFG, -1);
        wb(1'b0, OFF_PWR_STATUS, 0);
        chk(rd[ST_PLL_POS], 1'b0, "relock");
        chk(PLL_OUT_LOW_O, 1'b0, "div on");
        wb(1'b0, OFF_SYNTH_CFG, 0);
        chk(rd, 32'h07FF_3FFF, "fields");
        chk({PLL_MUL_O, PLL_DIV_O}, 19'h7FFFF, "max");
        wb(1'b1, OFF_SYNTH_CFG, 32'h3F01);
        @(posedge MCLK_I);
        chk(PLL_POWER_DOWN_O, 1'b1, "mul zero");
        $display("pll test done");
    endtask
    // verdict
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge MCLK_I);
        SRST_I <= 1'b0;
        t_reset;
        t_osc;
        t_pll;
        tally_and_finish;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge MCLK_I);
        miscompares++;
        $display("[ERR] %0t watchdog", $time);
        tally_and_finish;
    end
endmodule
